//--- rtl/spw_consts.svh
/*
  constants of the six-plus-two bit pulse-width modulator: register indices,
  field positions, reset values and timing counts.
  assumes it is included by bare name into design files that need it.
*/
`ifndef SPW_CONSTS_SVH
`define SPW_CONSTS_SVH

// register indices, byte address is four times the index
`define SPW_IDX_PIN_FUNC    10'h014
`define SPW_IDX_WAVE_CTRL   10'h020
`define SPW_IDX_DUTY_LOW    10'h021
`define SPW_IDX_DUTY_HIGH   10'h022
`define SPW_IDX_STATUS      10'h023

// field positions
`define SPW_POL_BIT         3
`define SPW_TCK_HI          2
`define SPW_TCK_LO          0
`define SPW_PRI_HI          3
`define SPW_PRI_LO          2
`define SPW_ALT_HI          1
`define SPW_ALT_LO          0
`define SPW_COARSE_HI       3
`define SPW_COARSE_LO       2
`define SPW_FINE_HI         1
`define SPW_FINE_LO         0

// reset values
`define SPW_RST_NIBBLE      4'h0
`define SPW_RST_DUTY        8'h00

// timing: ticks per sub-cycle and last tick index; pin field on code
`define SPW_SUB_TICKS       7'h40
`define SPW_LAST_POS        6'h3f
`define SPW_PIN_ON          2'h3

`endif

//--- rtl/spw_pkg.sv
/*
  types of the six-plus-two bit pulse-width modulator.
  assumes nothing beyond a SystemVerilog compiler.
*/
package spw_pkg;

  // tick divide select, code names give the divide factor
  typedef enum logic [2:0] {
    SPW_DIV_1    = 3'b000,
    SPW_DIV_2    = 3'b001,
    SPW_DIV_4    = 3'b010,
    SPW_DIV_8    = 3'b011,
    SPW_DIV_32   = 3'b100,
    SPW_DIV_128  = 3'b101,
    SPW_DIV_512  = 3'b110,
    SPW_DIV_2048 = 3'b111
  } spw_tick_sel_type;

  // generator states
  typedef enum logic [1:0] {
    SPW_GEN_IDLE   = 2'b00,
    SPW_GEN_RUN    = 2'b01,
    SPW_GEN_FROZEN = 2'b10
  } spw_gen_state_type;

  // axi write and read responses
  typedef enum logic [1:0] {
    SPW_RESP_OKAY   = 2'b00,
    SPW_RESP_SLVERR = 2'b10
  } spw_resp_type;

endpackage : spw_pkg

//--- rtl/spw_tick_div.sv
/*
  modulator tick divider: one-cycle tick every 1..2048 clocks.
  assumes run and select come from logic on the same clock.
*/
`timescale 1ns/10ps

module spw_tick_div #(
  parameter int CNT_W = 11
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // control
  input  wire logic                      run,
  input  wire spw_pkg::spw_tick_sel_type tick_sel,
  // tick out
  output logic                           tick
);
  import spw_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] mask;

  // divide factors are powers of two, so a mask on a free counter suffices
  always_comb begin
    unique case (tick_sel)
      SPW_DIV_1:    mask = CNT_W'(0);
      SPW_DIV_2:    mask = CNT_W'(1);
      SPW_DIV_4:    mask = CNT_W'(3);
      SPW_DIV_8:    mask = CNT_W'(7);
      SPW_DIV_32:   mask = CNT_W'(31);
      SPW_DIV_128:  mask = CNT_W'(127);
      SPW_DIV_512:  mask = CNT_W'(511);
      SPW_DIV_2048: mask = CNT_W'(2047);
    endcase
  end

  // counter restarts whenever the generator is not running
  always_comb begin
    cnt_d = run ? cnt_q + CNT_W'(1) : '0;
    tick  = run && ((cnt_q & mask) == mask);
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : spw_tick_div

//--- rtl/spw_top.sv
/*
  six-plus-two bit pulse-width modulator with an axi4-lite register slave.
  assumes core_halt and core_stop come from core logic on the same clock,
  and that pin drivers outside combine the output enables.
*/
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/10ps
`include "spw_consts.svh"

module spw_top (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                reset,
  // axi4-lite write address and data
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // axi4-lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output spw_pkg::spw_resp_type    s_axi_bresp,
  // axi4-lite read
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output spw_pkg::spw_resp_type    s_axi_rresp,
  // core power state
  input  wire logic                core_halt,
  input  wire logic                core_stop,
  // output pins
  output logic                     primary_pin_out,
  output logic                     primary_pin_oe,
  output logic                     alternate_wave_pin_out,
  output logic                     alternate_wave_pin_oe
);
  import spw_pkg::*;

  // register file
  logic [3:0] pin_function_select_q, pin_function_select_d;
  logic [3:0] wave_control_q,        wave_control_d;
  logic [3:0] duty_low_and_fine_q,   duty_low_and_fine_d;
  logic [3:0] duty_high_nibble_q,    duty_high_nibble_d;
  // bus state
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [9:0]  aw_idx_q, aw_idx_d;
  logic [31:0] wdata_q, wdata_d;
  logic        wstrb0_q, wstrb0_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  spw_resp_type bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wr_do, commit_wr;
  // generator state
  spw_gen_state_type state_q, state_d;
  logic [5:0] pos_q, pos_d;
  logic [1:0] sub_q, sub_d;
  logic [7:0] duty_setting_q, duty_setting_d;
  logic       commit_pend_q, commit_pend_d;
  logic       pri_out_q, pri_out_d, pri_oe_q, pri_oe_d;
  logic       alt_out_q, alt_out_d, alt_oe_q, alt_oe_d;
  logic       wave_q, wave_d;
  logic       tick, run, load, pri_en, alt_en, active;
  logic [5:0] coarse_duty;
  logic [1:0] duty_fine_tune;
  logic [6:0] eff_duty;

  // bus handshakes: one outstanding write and one read at a time
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_do         = aw_have_q && w_have_q;

  // address and data may arrive in either order; write once both are held
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_idx_d  = aw_idx_q;
    wdata_d   = wdata_q;
    wstrb0_d  = wstrb0_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    pin_function_select_d = pin_function_select_q;
    wave_control_d        = wave_control_q;
    duty_low_and_fine_d   = duty_low_and_fine_q;
    duty_high_nibble_d    = duty_high_nibble_q;
    commit_wr             = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      aw_idx_d  = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) bvalid_d = 1'b0;
    if (wr_do) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = SPW_RESP_OKAY;
      unique case (aw_idx_q)
        `SPW_IDX_PIN_FUNC:  if (wstrb0_q) pin_function_select_d = wdata_q[3:0];
        `SPW_IDX_WAVE_CTRL: if (wstrb0_q) wave_control_d = wdata_q[3:0];
        `SPW_IDX_DUTY_LOW:  if (wstrb0_q) duty_low_and_fine_d = wdata_q[3:0];
        `SPW_IDX_DUTY_HIGH: begin
          if (wstrb0_q) begin
            duty_high_nibble_d = wdata_q[3:0];
            commit_wr          = 1'b1;
          end
        end
        `SPW_IDX_STATUS: ;
        default: bresp_d = SPW_RESP_SLVERR;
      endcase
    end
  end

  // read path: data registered, status shows the generator's own state
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_rvalid && s_axi_rready) rvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = SPW_RESP_OKAY;
      rdata_d  = '0;
      unique case (s_axi_araddr[11:2])
        `SPW_IDX_PIN_FUNC:  rdata_d[3:0] = pin_function_select_q;
        `SPW_IDX_WAVE_CTRL: rdata_d[3:0] = wave_control_q;
        `SPW_IDX_DUTY_LOW:  rdata_d[3:0] = duty_low_and_fine_q;
        `SPW_IDX_DUTY_HIGH: rdata_d[3:0] = duty_high_nibble_q;
        `SPW_IDX_STATUS:    rdata_d[3:0] = {state_q == SPW_GEN_RUN, sub_q, commit_pend_q};
        default:            rresp_d = SPW_RESP_SLVERR;
      endcase
    end
  end

  // pin fields: either field switches the generator on, either pin drives
  assign pri_en = pin_function_select_q[`SPW_PRI_HI:`SPW_PRI_LO] == `SPW_PIN_ON;
  assign alt_en = pin_function_select_q[`SPW_ALT_HI:`SPW_ALT_LO] == `SPW_PIN_ON;
  // halt is not looked at: only stop freezes the ticks
  assign run = (state_q == SPW_GEN_RUN) && !core_stop;

  spw_tick_div #(.CNT_W (11)) u_tick_div (
    .clock    (clock),
    .reset    (reset),
    .run      (run),
    .tick     (tick),
    .tick_sel (spw_tick_sel_type'(wave_control_q[`SPW_TCK_HI:`SPW_TCK_LO]))
  );

  // effective duty: coarse plus one in sub-cycles below the fine code
  assign coarse_duty    = duty_setting_q[7:2];
  assign duty_fine_tune = duty_setting_q[1:0];
  assign eff_duty = {1'b0, coarse_duty} + {6'h00, sub_q < duty_fine_tune};
  assign active   = {1'b0, pos_q} < eff_duty;
  // duty swaps at a sub-cycle boundary so no sub-cycle sees a torn value
  assign load = commit_pend_q &&
                ((state_q == SPW_GEN_IDLE) || (tick && pos_q == `SPW_LAST_POS));

  // generator sequencing
  always_comb begin
    state_d        = state_q;
    pos_d          = pos_q;
    sub_d          = sub_q;
    duty_setting_d = duty_setting_q;
    commit_pend_d  = (commit_pend_q && !load) || commit_wr; // set wins over clear
    if (load) duty_setting_d = {duty_high_nibble_q, duty_low_and_fine_q};
    unique case (state_q)
      SPW_GEN_IDLE: begin
        pos_d = '0;
        sub_d = '0;
        if (pri_en || alt_en) state_d = core_stop ? SPW_GEN_FROZEN : SPW_GEN_RUN;
      end
      SPW_GEN_RUN: begin
        if (!(pri_en || alt_en)) begin
          state_d = SPW_GEN_IDLE;
        end else if (core_stop) begin
          state_d = SPW_GEN_FROZEN;
        end else if (tick) begin
          pos_d = pos_q + 6'h01;
          if (pos_q == `SPW_LAST_POS) sub_d = sub_q + 2'h1;
        end
      end
      SPW_GEN_FROZEN: begin
        if (!(pri_en || alt_en)) state_d = SPW_GEN_IDLE;
        else if (!core_stop) state_d = SPW_GEN_RUN;
      end
      default: state_d = SPW_GEN_IDLE;
    endcase
  end

  // waveform and pin drive; frozen keeps the last level on the pin
  always_comb begin
    wave_d = wave_q;
    if (state_q == SPW_GEN_IDLE) wave_d = 1'b0;
    else if (run) wave_d = active ^ wave_control_q[`SPW_POL_BIT];
    pri_oe_d  = pri_en;
    alt_oe_d  = alt_en;
    pri_out_d = pri_en && wave_d;
    alt_out_d = alt_en && wave_d;
  end

  assign primary_pin_out        = pri_out_q;
  assign primary_pin_oe         = pri_oe_q;
  assign alternate_wave_pin_out = alt_out_q;
  assign alternate_wave_pin_oe  = alt_oe_q;

  // registers of every group
  always_ff @(posedge clock) begin
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= '0;
      wdata_q   <= '0;
      wstrb0_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= SPW_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= SPW_RESP_OKAY;
      pin_function_select_q <= `SPW_RST_NIBBLE;
      wave_control_q        <= `SPW_RST_NIBBLE;
      duty_low_and_fine_q   <= `SPW_RST_NIBBLE;
      duty_high_nibble_q    <= `SPW_RST_NIBBLE;
      state_q        <= SPW_GEN_IDLE;
      pos_q          <= '0;
      sub_q          <= '0;
      duty_setting_q <= `SPW_RST_DUTY;
      commit_pend_q  <= 1'b0;
      wave_q    <= 1'b0;
      pri_out_q <= 1'b0;
      pri_oe_q  <= 1'b0;
      alt_out_q <= 1'b0;
      alt_oe_q  <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      aw_idx_q  <= aw_idx_d;
      wdata_q   <= wdata_d;
      wstrb0_q  <= wstrb0_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      pin_function_select_q <= pin_function_select_d;
      wave_control_q        <= wave_control_d;
      duty_low_and_fine_q   <= duty_low_and_fine_d;
      duty_high_nibble_q    <= duty_high_nibble_d;
      state_q        <= state_d;
      pos_q          <= pos_d;
      sub_q          <= sub_d;
      duty_setting_q <= duty_setting_d;
      commit_pend_q  <= commit_pend_d;
      wave_q    <= wave_d;
      pri_out_q <= pri_out_d;
      pri_oe_q  <= pri_oe_d;
      alt_out_q <= alt_out_d;
      alt_oe_q  <= alt_oe_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_tick_div32;
    tick && wave_control_q[2:0] == 3'b100 && !core_stop |=> (!tick || !run) [*8];
  endproperty
  a_tick_div32: assert property (p_tick_div32) else $error("tick too soon");
  // a pin disable at the wrap sends the sequencer idle instead of stepping
  property p_sub_advance;
    run && tick && pos_q == 6'h3f && (pri_en || alt_en)
      |=> sub_q == $past(sub_q) + 2'h1 && pos_q == 6'h00;
  endproperty
  a_sub_advance: assert property (p_sub_advance) else $error("no sub-cycle step");
  property p_fine_extra;
    run && sub_q == 2'h0 && duty_fine_tune != 2'h0 && pos_q == coarse_duty
      |=> wave_q == !$past(wave_control_q[3]);
  endproperty
  a_fine_extra: assert property (p_fine_extra) else $error("fine tick missing");
  property p_no_fine_late;
    run && sub_q == 2'h3 && pos_q == coarse_duty |=> wave_q == $past(wave_control_q[3]);
  endproperty
  a_no_fine_late: assert property (p_no_fine_late) else $error("sub-cycle 3 extended");
  property p_commit_sets;
    wr_do && aw_idx_q == 10'h022 && wstrb0_q |=> commit_pend_q;
  endproperty
  a_commit_sets: assert property (p_commit_sets) else $error("high nibble write lost");
  property p_commit_load;
    load |=> duty_setting_q == {$past(duty_high_nibble_q), $past(duty_low_and_fine_q)};
  endproperty
  a_commit_load: assert property (p_commit_load) else $error("duty not assembled");
  property p_stop_freeze;
    state_q != SPW_GEN_IDLE && core_stop && (pri_en || alt_en)
      |=> $stable(pos_q) && $stable(sub_q) && $stable(wave_q);
  endproperty
  a_stop_freeze: assert property (p_stop_freeze) else $error("generator moved in stop");
  property p_halt_runs;
    run && core_halt && tick && pos_q != 6'h3f && (pri_en || alt_en)
      |=> pos_q == $past(pos_q) + 6'h01;
  endproperty
  a_halt_runs: assert property (p_halt_runs) else $error("stalled in halt");
  property p_pri_pin;
    pin_function_select_q[3:2] == 2'b11 ##1 pin_function_select_q[3:2] == 2'b11
      |-> primary_pin_oe && (primary_pin_out == wave_q);
  endproperty
  a_pri_pin: assert property (p_pri_pin) else $error("primary pin not driven");
  property p_alt_pin;
    pin_function_select_q[1:0] != 2'b11 |=> !alternate_wave_pin_oe && !alternate_wave_pin_out;
  endproperty
  a_alt_pin: assert property (p_alt_pin) else $error("alternate pin driven while off");

endmodule : spw_top

//--- tb/spw_pin_load.sv
/*
  load on the two shared wave pins: pull-up plus counters of high clocks.
  assumes the pins are sampled on the bench clock.
*/
`timescale 1ns/10ps

module spw_pin_load (
  // clock and window control
  input  wire logic   clock,
  input  wire logic   clear,
  // pins from the modulator
  input  wire logic   primary_pin_out,
  input  wire logic   primary_pin_oe,
  input  wire logic   alternate_wave_pin_out,
  input  wire logic   alternate_wave_pin_oe,
  // resolved levels and counts
  output logic        primary_level,
  output logic        alternate_level,
  output logic [31:0] primary_high_count,
  output logic [31:0] alternate_high_count
);
  // an undriven pin goes to the pull-up level, never keeps the last value
  assign primary_level   = primary_pin_oe ? primary_pin_out : 1'b1;
  assign alternate_level = alternate_wave_pin_oe ? alternate_wave_pin_out : 1'b1;

  // clear opens a window; every later edge adds one if the pin is high
  always_ff @(posedge clock) begin
    if (clear) begin
      primary_high_count   <= 32'h0;
      alternate_high_count <= 32'h0;
    end else begin
      primary_high_count   <= primary_high_count + {31'h0, primary_level};
      alternate_high_count <= alternate_high_count + {31'h0, alternate_level};
    end
  end
endmodule : spw_pin_load

//--- tb/spw_top_bench.sv
/*
  self-checking bench of the modulator: register bus, wave counts, stop.
  assumes the pin load model and the design files are compiled first.
*/
`timescale 1ns/10ps

module spw_top_bench;
  import spw_pkg::*;

  typedef struct {
    logic [3:0] wctl;
    logic [3:0] low;
    logic [3:0] high;
    logic [3:0] pins;
    logic       halt;
    int         div;
    int         exp;
  } spw_row_type;

  logic        clock, reset, clear, core_halt, core_stop;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, pcnt, acnt;
  logic [1:0]  bresp, rresp, rsp;
  logic        pout, poe, aout, aoe, plvl, alvl, lvl;
  int          fails, checks_done, win;
  spw_row_type rows [5];

  spw_top u_dut (.clock(clock), .reset(reset),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .core_halt(core_halt), .core_stop(core_stop),
    .primary_pin_out(pout), .primary_pin_oe(poe),
    .alternate_wave_pin_out(aout), .alternate_wave_pin_oe(aoe));

  spw_pin_load u_load (.clock(clock), .clear(clear), .primary_pin_out(pout),
    .primary_pin_oe(poe), .alternate_wave_pin_out(aout), .alternate_wave_pin_oe(aoe),
    .primary_level(plvl), .alternate_level(alvl), .primary_high_count(pcnt),
    .alternate_high_count(acnt));

  // one compare for every check; mismatches are counted
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ready is looked at on the falling edge, where it is already settled
  task automatic axi_wr(input logic [11:0] a, input logic [3:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    r = 2'h3;
    tb = 1'b0;
    @(posedge clock);
    awaddr  <= a;
    wdata   <= {28'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 64 && !tb; n++) begin
      @(negedge clock);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      if (tb) r = bresp;
      @(posedge clock);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    if (!tb) begin
      fails++;
      $display("write to %h got no response", a);
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    r = 2'h3;
    tr = 1'b0;
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 64 && !tr; n++) begin
      @(negedge clock);
      ta = arvalid && arready;
      tr = rvalid && rready;
      d = rdata;
      r = rresp;
      @(posedge clock);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    if (!tr) begin
      fails++;
      $display("read of %h got no response", a);
    end
  endtask : axi_rd

  // counts high clocks over exactly w edges, result settled on the falling edge
  task automatic measure(input int w);
    @(posedge clock);
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (w) @(posedge clock);
    @(negedge clock);
  endtask : measure

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // watchdog: the whole run needs well under half this span
  initial begin
    repeat (90000) @(posedge clock);
    fails++;
    $display("watchdog expired");
    end_of_test();
  end

  initial begin
    {reset, clear, core_halt, core_stop} = 4'b1100;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 12'h0;
    araddr = 12'h0;
    wdata = 32'h0;
    fails = 0;
    checks_done = 0;
    // rows: control, low, high, pins, halt, divide, high clocks per window
    rows = '{'{4'hc, 4'h3, 4'h4, 4'h3, 1'b0, 32, 6048},
             '{4'h3, 4'h0, 4'h0, 4'hf, 1'b0, 8, 0},
             '{4'h2, 4'h6, 4'h1, 4'hc, 1'b1, 4, 88},
             '{4'h9, 4'hf, 4'hf, 4'hc, 1'b0, 2, 2},
             '{4'h0, 4'h1, 4'h8, 4'hc, 1'b0, 1, 129}};
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    axi_rd(12'h050, rd, rsp);
    check(rd, 32'h0);
    axi_rd(12'h088, rd, rsp);
    check(rd, 32'h0);
    axi_rd(12'h0c0, rd, rsp);
    check({rd[31:2], rsp}, {30'h0, SPW_RESP_SLVERR});
    axi_wr(12'h0c0, 4'h5, rsp);
    check({30'h0, rsp}, {30'h0, SPW_RESP_SLVERR});
    for (int i = 0; i < 16; i++) begin
      axi_wr(12'h080, i[3:0], rsp);
      axi_rd(12'h080, rd, rsp);
      check(rd, {28'h0, i[3:0]});
    end
    $display("test registers done");
    // each row: tick, duty low then high, polarity, then pins
    for (int i = 0; i < 5; i++) begin
      win = 256 * rows[i].div;
      axi_wr(12'h050, 4'h0, rsp);
      axi_wr(12'h080, rows[i].wctl & 4'h7, rsp);
      axi_wr(12'h084, rows[i].low, rsp);
      axi_wr(12'h088, rows[i].high, rsp);
      axi_wr(12'h080, rows[i].wctl, rsp);
      axi_wr(12'h050, rows[i].pins, rsp);
      core_halt <= rows[i].halt;
      repeat (2 * win) @(posedge clock);
      measure(win);
      check(pcnt, rows[i].pins[3:2] == 2'b11 ? rows[i].exp : win);
      check(acnt, rows[i].pins[1:0] == 2'b11 ? rows[i].exp : win);
      $display("test row %0d done", i);
    end
    // low register alone must not change the running duty
    axi_wr(12'h084, 4'h3, rsp);
    measure(256);
    check(pcnt, 32'd129);
    axi_wr(12'h088, 4'h8, rsp);
    repeat (512) @(posedge clock);
    measure(256);
    check(pcnt, 32'd131);
    $display("test commit done");
    // stop freezes the pin at whatever level it had
    @(posedge clock);
    core_stop <= 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    lvl = plvl;
    measure(300);
    check(pcnt, lvl ? 32'd300 : 32'd0);
    @(posedge clock);
    core_stop <= 1'b0;
    repeat (512) @(posedge clock);
    measure(256);
    check(pcnt, 32'd131);
    $display("test stop done");
    // a second reset drops both pins back to the pull-up
    @(posedge clock);
    reset <= 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    measure(64);
    check(pcnt, 32'd64);
    check(acnt, 32'd64);
    axi_rd(12'h050, rd, rsp);
    check(rd, 32'h0);
    axi_rd(12'h08c, rd, rsp);
    check(rd, 32'h0);
    $display("test second reset done");
    end_of_test();
  end
endmodule : spw_top_bench
